// ---- rtl/spi_flags_pkg.sv ----
// Purpose: constants and types shared by the serial port status/control block
// Assumes: 32-bit Avalon-MM register bus, byte addressing
// Notes: bit positions follow the status/control register layout
package spi_flags_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_DATA_WINDOW = 4'h4;
  localparam int ADDR_W = 4;

  // ****************************************
  // status_control_register field positions
  // ****************************************
  localparam int BIT_UNIT_ENABLE = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_RX_OVERFLOW = 6;
  localparam int BIT_TX_FULL = 1;
  localparam int BIT_RX_FULL = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic unit_enable_bit;
    logic idle_halt_bit;
    logic receive_overflow_flag;
    logic tx_buffer_full_flag;
    logic rx_buffer_full_flag;
  } status_type;

  localparam status_type STATUS_CLEAR = '{default: 1'b0};

endpackage

// ---- rtl/spi_status_control.sv ----
// Purpose: status/control flags and data window of a slave-mode serial port
// Assumes: clk at 10 MHz; serial_clock_pin is the link clock from the peer
// Notes: a minimal slave shifter stands on the link clock to produce the
//        buffer transfer events; events cross as toggles, the run level as a level, both through 2-FF syncs
//        the link side has no reset; it clears while the unit is stopped,
//        so the peer must give a few clock edges with select high first;
//        events that cross back are honoured only while the unit runs
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module spi_status_control
  import spi_flags_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // device power state
  input wire logic idle_mode,
  // serial pins
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic slave_select_pin_n,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic pins_owned
);

  // bit counter wraps after one full word
  localparam int CNT_W = $clog2(DATA_W);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(DATA_W - 1);

  // ****************************************
  // bus slave
  // ****************************************
  status_type stat_reg;
  logic [DATA_W-1:0] transmit_holding_buffer;
  logic [DATA_W-1:0] receive_holding_buffer;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic wr_stat;
  logic wr_data;
  logic rd_data;
  logic [15:0] stat_word;
  // link-side word and its acceptance, also used by the read path
  logic [DATA_W-1:0] rx_word_reg;
  logic rx_accept;

  // one wait cycle per access; the request is taken when waitrequest is low
  // the wait cycle costs bus time but lets read data come from a flop
  // rather than from the wide read mux in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_stat = write & ack_reg & (address == ADDR_STATUS_CONTROL);
  assign wr_data = write & ack_reg & (address == ADDR_DATA_WINDOW);
  assign rd_data = read & ack_reg & (address == ADDR_DATA_WINDOW);

  // only implemented bits are placed; everything else stays zero
  // field positions come from the package; the holes are never driven
  always_comb begin
    stat_word = 16'h0000;
    stat_word[BIT_UNIT_ENABLE] = stat_reg.unit_enable_bit;
    stat_word[BIT_IDLE_HALT] = stat_reg.idle_halt_bit;
    stat_word[BIT_RX_OVERFLOW] = stat_reg.receive_overflow_flag;
    stat_word[BIT_TX_FULL] = stat_reg.tx_buffer_full_flag;
    stat_word[BIT_RX_FULL] = stat_reg.rx_buffer_full_flag;
  end

  // read data is registered in the wait cycle so it stands at the taking edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read & ~ack_reg) begin
      if (address == ADDR_STATUS_CONTROL) begin
        readdata_reg <= {16'h0000, stat_word};
      end else if (address == ADDR_DATA_WINDOW) begin
        // a word accepted in this very cycle is the one to return, since
        // the taking edge that follows clears the full flag for it
        readdata_reg <= 32'(rx_accept ? rx_word_reg : receive_holding_buffer);
      end else begin
        // unmapped offsets read as zero
        readdata_reg <= 32'h0000_0000;
      end
    end
  end

  // bus read data straight from the flop
  assign readdata = readdata_reg;

  // ****************************************
  // unit run state
  // ****************************************
  logic unit_run;

  // halted in idle only when software asked for it
  // idle_mode is on this clock, so it needs no synchroniser
  assign unit_run = stat_reg.unit_enable_bit & ~(stat_reg.idle_halt_bit & idle_mode);
  // pins follow the enable bit alone, not the idle halt
  assign pins_owned = stat_reg.unit_enable_bit;

  // ****************************************
  // link-to-core event synchronisers
  // ****************************************
  logic tx_req_tgl_reg;
  logic tx_ack_tgl_reg;
  logic rx_tgl_reg;
  logic [1:0] tx_ack_sync_reg;
  logic [1:0] rx_sync_reg;
  logic tx_ack_seen_reg;
  logic rx_seen_reg;
  logic tx_taken;
  logic rx_done;

  // two stages per toggle, then a third flop to find the change; only the
  // second stage is read, so a metastable first stage never reaches logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_ack_sync_reg <= 2'b00;
      rx_sync_reg <= 2'b00;
      tx_ack_seen_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
    end else begin
      tx_ack_sync_reg <= {tx_ack_sync_reg[0], tx_ack_tgl_reg};
      rx_sync_reg <= {rx_sync_reg[0], rx_tgl_reg};
      tx_ack_seen_reg <= tx_ack_sync_reg[1];
      rx_seen_reg <= rx_sync_reg[1];
    end
  end

  // the link side zeroes its toggles whenever it stops, which looks like an
  // event here; events count only while the unit runs, which also masks the
  // unknown toggles of a link that has not been clocked since power-up;
  // a word that completes just as the unit stops is dropped with it
  assign tx_taken = (tx_ack_sync_reg[1] ^ tx_ack_seen_reg) & unit_run;
  assign rx_done = (rx_sync_reg[1] ^ rx_seen_reg) & unit_run;

  // ****************************************
  // status/control register and buffers
  // ****************************************
  status_type stat_next;

  // a word landing in the cycle the buffer is read counts as read first
  assign rx_accept = rx_done & (~stat_reg.rx_buffer_full_flag | rd_data);

  // next flag state; later lines win, so each set stands after its matching clear
  // and leaves the flag set, except that the disabled-unit clear of tx_buffer_full_flag stands last
  always_comb begin
    stat_next = stat_reg;
    if (wr_stat && byteenable[1]) begin
      stat_next.unit_enable_bit = writedata[BIT_UNIT_ENABLE];
      stat_next.idle_halt_bit = writedata[BIT_IDLE_HALT];
    end
    // write-zero clears, write-one is ignored; a new overflow wins
    if (wr_stat && byteenable[0] && !writedata[BIT_RX_OVERFLOW]) begin
      stat_next.receive_overflow_flag = 1'b0;
    end
    if (rx_done && !rx_accept) begin
      stat_next.receive_overflow_flag = 1'b1;
    end
    if (tx_taken) begin
      stat_next.tx_buffer_full_flag = 1'b0;
    end
    if (wr_data) begin
      stat_next.tx_buffer_full_flag = 1'b1;
    end
    if (rd_data) begin
      stat_next.rx_buffer_full_flag = 1'b0;
    end
    if (rx_accept) begin
      stat_next.rx_buffer_full_flag = 1'b1;
    end
    // a disabled unit never sends, so a waiting word is dropped
    if (!stat_reg.unit_enable_bit) begin
      stat_next.tx_buffer_full_flag = 1'b0;
    end
  end

  // flag register; reset leaves the unit off with both buffers empty
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_reg <= STATUS_CLEAR;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // holding buffers; a write while full replaces the waiting word
  // each write flips the request toggle, so a second write before the link
  // sees the first flips it back and neither word goes out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      transmit_holding_buffer <= '0;
      receive_holding_buffer <= '0;
      tx_req_tgl_reg <= 1'b0;
    end else begin
      if (wr_data) begin
        if (byteenable[0]) begin
          transmit_holding_buffer[7:0] <= writedata[7:0];
        end
        if (byteenable[1]) begin
          transmit_holding_buffer[DATA_W-1:8] <= writedata[DATA_W-1:8];
        end
        tx_req_tgl_reg <= ~tx_req_tgl_reg;
      end
      if (rx_accept) begin
        receive_holding_buffer <= rx_word_reg;
      end
    end
  end

  // ****************************************
  // link domain: slave shifter on the peer's clock
  // ****************************************
  logic [1:0] run_sync_reg;
  logic [1:0] tx_req_sync_reg;
  logic tx_req_seen_reg;
  logic [DATA_W-1:0] shift_register_stage;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic link_run;
  logic word_start;

  // the unit's run level as seen on the link side
  assign link_run = run_sync_reg[1];
  // a word starts on the first selected edge after the count wraps
  assign word_start = (bit_cnt_reg == '0) & ~slave_select_pin_n;

  // run level and pending-word toggle enter the link domain through two stages
  always_ff @(posedge serial_clock_pin) begin
    run_sync_reg <= {run_sync_reg[0], unit_run};
    tx_req_sync_reg <= {tx_req_sync_reg[0], tx_req_tgl_reg};
  end

  // the link clock stops between frames, so state is cleared by the
  // synchronised run level rather than by a reset on this clock
  // the bit count survives a select that rises mid-word, so a cut frame
  // resumes where it stopped rather than starting a new word
  always_ff @(posedge serial_clock_pin) begin
    if (!link_run) begin
      bit_cnt_reg <= '0;
      shift_register_stage <= '0;
      tx_req_seen_reg <= tx_req_sync_reg[1];
      tx_ack_tgl_reg <= 1'b0;
      rx_tgl_reg <= 1'b0;
      rx_word_reg <= '0;
    end else if (!slave_select_pin_n) begin
      bit_cnt_reg <= (bit_cnt_reg == LAST_BIT) ? '0 : bit_cnt_reg + 1'b1;
      if (word_start && (tx_req_sync_reg[1] != tx_req_seen_reg)) begin
        // holding buffer is stable: it changes only on a write, which
        // toggles the request again and is seen at the next word start
        shift_register_stage <= {transmit_holding_buffer[DATA_W-2:0], serial_in_pin};
        tx_req_seen_reg <= tx_req_sync_reg[1];
        tx_ack_tgl_reg <= ~tx_ack_tgl_reg;
      end else begin
        shift_register_stage <= {shift_register_stage[DATA_W-2:0], serial_in_pin};
      end
      if (bit_cnt_reg == LAST_BIT) begin
        rx_word_reg <= {shift_register_stage[DATA_W-2:0], serial_in_pin};
        rx_tgl_reg <= ~rx_tgl_reg;
      end
    end
  end

  // output bit: first bit comes straight from the holding buffer
  // because the shifter is loaded only by the first rising edge itself
  always_comb begin
    if (word_start && (tx_req_sync_reg[1] != tx_req_seen_reg)) begin
      serial_out_pin = transmit_holding_buffer[DATA_W-1];
    end else begin
      serial_out_pin = shift_register_stage[DATA_W-1];
    end
  end

  // drive the data line only while enabled and selected by the peer
  assign serial_out_oe = stat_reg.unit_enable_bit & ~slave_select_pin_n;

endmodule // spi_status_control

// ---- verif/spi_flags_checker.sv ----
// Purpose: port-level checks for the serial status block
// Assumes: all checks on the core clock
// Notes: bound into every instance of the block
`timescale 1ns/10ps
module spi_flags_checker
  import spi_flags_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic serial_out_oe,
  input wire logic pins_owned
);
  // ****
  // bus and flag properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic ack_rd;
  // read accepted in this cycle
  assign ack_rd = read & ~waitrequest;
  a_wait_first: assert property ($rose(read | write) |-> waitrequest) else $error("no wait");
  a_ack_next: assert property ((read | write) && waitrequest |=> !waitrequest) else $error("no ack");
  a_upper_zero: assert property (ack_rd |-> readdata[31:16] == 16'h0000) else $error("upper");
  a_unimpl_zero: assert property (ack_rd && address == ADDR_STATUS_CONTROL
    |-> (readdata & 32'h0000_5FBC) == 32'h0000_0000) else $error("unimpl");
  a_en_to_pins: assert property (write && !waitrequest && address == ADDR_STATUS_CONTROL && byteenable[1]
    |=> pins_owned == $past(writedata[15])) else $error("pins");
  a_oe_needs_en: assert property (serial_out_oe |-> pins_owned) else $error("oe");
  a_reset_idle: assert property ($fell(sys_rst) |-> !pins_owned && readdata == 32'h0000_0000) else $error("rst");
  a_rd_hold: assert property ($changed(readdata) |-> $past(read) && $past(waitrequest)) else $error("hold");
  c_status_read: cover property (ack_rd && address == ADDR_STATUS_CONTROL);
  c_data_write: cover property (write && !waitrequest && address == ADDR_DATA_WINDOW);
  c_driving: cover property (serial_out_oe);
endmodule // spi_flags_checker
bind spi_status_control spi_flags_checker chk (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .serial_out_oe(serial_out_oe), .pins_owned(pins_owned));

// ---- verif/spi_peer_model.sv ----
// Purpose: serial peer that clocks one word frame at a time
// Assumes: device samples data on the rising serial clock
// Notes: the clock stands still between frames
`timescale 1ns/10ps
module spi_peer_model (
  output logic sclk,
  output logic sdi,
  output logic ss_n,
  input wire logic sdo
);
  // ****
  // frame generator
  // ****
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    ss_n = 1'b1;
  end
  // lead-in edges with select high give the crossings time to settle
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 0; i < 4; i++) begin
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    ss_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = tx[i];
      #3 rx[i] = sdo;
      sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #3 ss_n = 1'b1;
    sdi = ~sdi; // released line shows the inverse of its last value
  endtask
endmodule // spi_peer_model

// ---- verif/spi_status_control_test.sv ----
// Purpose: register-level test of the serial status block
// Assumes: peer frames run at 6 ns per bit
// Notes: ten-cycle waits cover the flag crossings
`timescale 1ns/10ps
module spi_status_control_test
  import spi_flags_pkg::*;
;
  logic clk, sys_rst, read, write, idle_mode, sclk, sdi, ss_n, so, oe, owned, waitrequest;
  logic [3:0] address;
  logic [31:0] writedata, readdata;
  logic [15:0] pw;
  int n_mismatch, tests_run, cyc;
  // ****
  // clock, device and peer
  // ****
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  spi_status_control dut (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .idle_mode(idle_mode), .serial_clock_pin(sclk), .serial_in_pin(sdi), .slave_select_pin_n(ss_n),
    .serial_out_pin(so), .serial_out_oe(oe), .pins_owned(owned));
  // a released output line is pulled high
  spi_peer_model peer (.sclk(sclk), .sdi(sdi), .ss_n(ss_n), .sdo(oe ? so : 1'b1));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e, nm);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic xfer(input logic [15:0] t);
    peer.frame(t, pw);
    repeat (10) @(posedge clk);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, well above the roughly 120 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0000_0000;
    idle_mode = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(16'h0000);
    rd(ADDR_STATUS_CONTROL, 32'h0000_0000, "reset");
    rd(4'h8, 32'h0000_0000, "unmapped");
    wr(ADDR_STATUS_CONTROL, 32'hFFFF_FFFF);
    rd(ADDR_STATUS_CONTROL, 32'h0000_A000, "ones");
    chk(32'(owned), 32'h0000_0001, "owned");
    wr(ADDR_STATUS_CONTROL, 32'h0000_8000);
    wr(ADDR_DATA_WINDOW, 32'h0000_C3A5);
    rd(ADDR_STATUS_CONTROL, 32'h0000_8002, "txfull");
    xfer(16'h5A3C);
    chk(32'(pw), 32'h0000_C3A5, "sent");
    rd(ADDR_STATUS_CONTROL, 32'h0000_8001, "rxfull");
    xfer(16'h1111);
    rd(ADDR_STATUS_CONTROL, 32'h0000_8041, "ovf");
    rd(ADDR_DATA_WINDOW, 32'h0000_5A3C, "kept");
    rd(ADDR_STATUS_CONTROL, 32'h0000_8040, "rdclr");
    wr(ADDR_STATUS_CONTROL, 32'h0000_8000);
    rd(ADDR_STATUS_CONTROL, 32'h0000_8000, "ovfclr");
    wr(ADDR_STATUS_CONTROL, 32'h0000_A000);
    idle_mode <= 1'b1;
    xfer(16'h7777);
    rd(ADDR_STATUS_CONTROL, 32'h0000_A000, "halted");
    idle_mode <= 1'b0;
    xfer(16'h2468);
    rd(ADDR_STATUS_CONTROL, 32'h0000_A001, "resumed");
    rd(ADDR_DATA_WINDOW, 32'h0000_2468, "word");
    wr(ADDR_STATUS_CONTROL, 32'h0000_0000);
    @(posedge clk);
    chk(32'(owned), 32'h0000_0000, "off");
    tally_and_finish;
  end
endmodule // spi_status_control_test
